//--- utxq_pkg.sv
// Shared constants, types and helpers for the transmit mode and slot block
package utxq_pkg;
   localparam int SLOTS = 4;
   localparam int SLOT_BYTES = 7;
   localparam logic [7:0] DATA_LAST_POS = 8'h06;
   localparam logic [7:0] FILL_FIRST = 8'hd3;
   localparam logic [7:0] FILL_SECOND = 8'hc2;
   localparam logic [7:0] LEN_RESET = 8'h00;
   localparam logic [7:0] LEN_CAP_SHORT = 8'h3e;
   localparam logic [7:0] LEN_CAP_LONG = 8'hff;
   localparam logic [7:0] SOF_CHAR = 8'h15;
   localparam logic [7:0] EOF_CHAR = 8'h54;
   localparam logic [1:0] SLOT_RESET = 2'h0;
   localparam logic [3:0] KA_OFF = 4'h0;
   localparam logic [3:0] KA_ZERO_GAP = 4'h1;
   localparam logic [3:0] KA_TOP_CODE = 4'hc;
   localparam int CLK_MHZ = 200;
   localparam int KA_MAX_US = 10240;
   localparam int KA_MAX_CYCLES = KA_MAX_US * CLK_MHZ;
   localparam int LINE_BITS = 12;
   localparam int BAUD_DIV_DEFAULT = 100;

   // Host configuration, held in the block
   typedef struct packed {
      logic pause;
      logic preamble;
      logic queue_en;
      logic long_msg;
      logic odd_par;
      logic no_stop;
      logic no_pre;
      logic tx_raw;
      logic rx_raw;
      logic [3:0] ka_code;
   } utxq_cfg_s;
   localparam utxq_cfg_s CFG_RESET = '{queue_en: 1'b1, ka_code: KA_OFF,
      default: 1'b0};

   // Status seen by the host
   typedef struct packed {
      logic empty;
      logic full;
      logic overflow;
      logic busy;
      logic idle;
      logic [1:0] load_slot;
      logic [1:0] send_slot;
   } utxq_stat_s;
   localparam utxq_stat_s STAT_RESET = 9'h110;

   // Default content of one slot position
   function automatic logic [7:0] slot_default(input int pos);
      if (pos == 0) return LEN_RESET;
      return pos[0] ? FILL_FIRST : FILL_SECOND;
   endfunction

   // Manchester code of a nibble: data bit then its complement
   function automatic logic [7:0] man_encode(input logic [3:0] n);
      return {~n[3], n[3], ~n[2], n[2], ~n[1], n[1], ~n[0], n[0]};
   endfunction

   // Data bits of a Manchester character
   function automatic logic [3:0] man_decode(input logic [7:0] c);
      return {c[6], c[4], c[2], c[0]};
   endfunction
endpackage

//--- utxq_slot_mem.sv
// Four slots of seven bytes with default restore and registered reads
`timescale 1ns/100ps
`default_nettype none
module utxq_slot_mem
   import utxq_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Restore controls
   input wire logic clear_all_i,
   input wire logic restore_i,
   input wire logic [1:0] restore_slot_i,
   // Write port
   input wire logic wr_en_i,
   input wire logic [1:0] wr_slot_i,
   input wire logic [2:0] wr_pos_i,
   input wire logic [7:0] wr_data_i,
   // Read ports
   input wire logic [1:0] a_slot_i,
   input wire logic [2:0] a_pos_i,
   output logic [7:0] a_data_o,
   input wire logic [1:0] b_slot_i,
   input wire logic [2:0] b_pos_i,
   output logic [7:0] b_data_o
);
   logic [7:0] mem_q [SLOTS][SLOT_BYTES];

   // Storage with whole-store and per-slot restore
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      for (int s = 0; s < SLOTS; s++) begin
         for (int p = 0; p < SLOT_BYTES; p++) begin
            if (!rst_n_i) begin
               mem_q[s][p] <= slot_default(p);
            end else if (clear_all_i || (restore_i &&
                         restore_slot_i == 2'(s))) begin
               mem_q[s][p] <= slot_default(p);
            end else if (wr_en_i && wr_slot_i == 2'(s) &&
                         wr_pos_i == 3'(p)) begin
               mem_q[s][p] <= wr_data_i;
            end
         end
      end
   end

   // Registered reads; positions past the slot read as zero
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         a_data_o <= 8'h00;
         b_data_o <= 8'h00;
      end else begin
         a_data_o <= (a_pos_i > 3'h6) ? 8'h00 : mem_q[a_slot_i][a_pos_i];
         b_data_o <= (b_pos_i > 3'h6) ? 8'h00 : mem_q[b_slot_i][b_pos_i];
      end
   end
endmodule
`default_nettype wire

//--- utxq_char_ser.sv
// Line character serializer: start, eight bits, parity, two stops
`timescale 1ns/100ps
`default_nettype none
module utxq_char_ser
   import utxq_pkg::*;
#(
   parameter int BAUD_DIV = BAUD_DIV_DEFAULT
)(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic halt_i,
   // Character in
   input wire logic chr_valid_i,
   input wire logic [7:0] chr_data_i,
   input wire logic odd_par_i,
   output logic chr_ready_o,
   // Line
   output logic line_o
);
   if (BAUD_DIV < 2 || BAUD_DIV > 65535) begin : g_chk
      $error("BAUD_DIV out of range");
   end

   logic [LINE_BITS-1:0] shift_q;
   logic [3:0] bits_q;
   logic [15:0] div_q;
   wire par = odd_par_i ? ~^chr_data_i : ^chr_data_i;
   wire tick = (div_q == 16'(BAUD_DIV - 1));

   assign chr_ready_o = (bits_q == 4'h0) && !halt_i;

   // Shift out one line bit per baud period, idle high
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_q <= '1;
         bits_q <= 4'h0;
         div_q <= 16'h0000;
         line_o <= 1'b1;
      end else if (halt_i) begin
         shift_q <= '1;
         bits_q <= 4'h0;
         div_q <= 16'h0000;
         line_o <= 1'b1;
      end else if (chr_valid_i && chr_ready_o) begin
         shift_q <= {2'b11, par, chr_data_i, 1'b0};
         bits_q <= 4'(LINE_BITS);
         div_q <= 16'h0000;
         line_o <= 1'b1;
      end else begin
         line_o <= (bits_q != 4'h0) ? shift_q[0] : 1'b1;
         if (bits_q != 4'h0) begin
            div_q <= tick ? 16'h0000 : div_q + 16'h0001;
            if (tick) begin
               shift_q <= {1'b1, shift_q[LINE_BITS-1:1]};
               bits_q <= bits_q - 4'h1;
            end
         end
      end
   end

   property p_parity;
      @(posedge clk_i) disable iff (!rst_n_i)
      (chr_valid_i && chr_ready_o) |=> (^shift_q[9:1]) == $past(odd_par_i);
   endproperty
   a_parity: assert property (p_parity) // see (R08)
      else $error("character parity does not match parity control");
endmodule
`default_nettype wire

//--- utxq_top.sv
// Transmit mode arbiter, slot store control and receive byte assembly
//
// Summary of operation
// (R01) Power-down input resets all state and store, stops send and receive.
// (R02) Preamble mode sends start characters gap-free; only pause beats it.
// (R03) Keep-alive sends an end character after a 4-bit coded idle gap.
// (R04) Keep-alive is lowest priority; pause, preamble and queue pre-empt it.
// (R05) Queue mode sends a loaded message given receive room or long enable.
// (R06) Long enable raises length cap to 255 and ignores receive room.
// (R07) Pause idles line after the current character, freezes busy and idle.
// (R08) Odd-parity control selects odd parity, otherwise even parity.
// (R09) Omit-end control drops the end character; host sets long past 62.
// (R10) Omit-start control drops the preamble; unframed data is not stored.
// (R11) Transmit raw sends each byte as one character, no Manchester code.
// (R12) Receive raw stores one byte per received character, no decoding.
// (R13) Four slots of seven bytes; load selector fills, send selector drains.
// (R14) Position 0 holds length, positions 1 to 6 hold data.
// (R15) Clear command zeroes both selectors and restores all 28 bytes.
// (R16) Length above 62 is stored as 3Eh; long enable raises cap to FFh.
// (R17) Host computes length with fill bytes, without framing characters.
// (R18) Beyond six bytes, fill bytes alternating D3h and C2h are sent.
// (R19) Slot default: length 00h, data D3h, C2h alternating from position 1.
// (R20) Host drains the receive store fast enough when long messages are on.
// (R21) Advance bumps load selector with wrap, then releases prior slot.
// (R22) Empty if selectors equal, full if load one behind; refuse and flag.
// (R23) A fully sent slot returns to defaults and frees for loading.
// (R24) Start character is 15h and end character is 54h, both unencoded.
// (R25) Mode priority is evaluated only at character boundaries.
// (R26) Mode controls are held bits acting on the next character or message.
`timescale 1ns/100ps
`default_nettype none
module utxq_top
   import utxq_pkg::*;
#(
   parameter int BAUD_DIV = BAUD_DIV_DEFAULT,
   parameter int KA_MAX_CYC = KA_MAX_CYCLES
)(
   // Clock, reset and power-down pin
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire logic POWER_DOWN_I,
   // Configuration
   input wire logic CFG_WE_I,
   input wire utxq_cfg_s CFG_I,
   // Slot commands and host access
   input wire logic CLEAR_OUTGOING_STORE_CMD_I,
   input wire logic ADVANCE_LOAD_SLOT_CMD_I,
   input wire logic WR_EN_I,
   input wire logic [2:0] WR_POS_I,
   input wire logic [7:0] WR_DATA_I,
   input wire logic [2:0] RD_POS_I,
   output logic [7:0] RD_DATA_O,
   // Status
   output var utxq_stat_s STATUS_O,
   // Receive side
   input wire logic [7:0] RX_SPACE_I,
   input wire logic RX_CHAR_VALID_I,
   input wire logic [7:0] RX_CHAR_I,
   output logic RX_BYTE_VALID_O,
   output logic [7:0] RX_BYTE_O,
   // Line
   output logic TX_LINE_O
);
   localparam int KW = $clog2(KA_MAX_CYC + 1);
   if (KA_MAX_CYC < 1024) begin : g_chk
      $error("KA_MAX_CYC too small");
   end

   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_SOF = 5'h02,
      S_BYTE = 5'h04,
      S_EOF = 5'h08,
      S_DONE = 5'h10
   } utxq_state_e;

   logic pd_meta_q, pd_q;
   utxq_cfg_s cfg_q;
   logic [1:0] load_slot_selector_q, send_slot_q;
   logic overflow_q;
   utxq_state_e state_q, state_d;
   logic [7:0] idx_q, idx_d, len_q, len_d;
   logic half_q, half_d;
   logic m_no_stop_q, m_raw_q;
   logic [4:0] seen_q;
   logic [KW-1:0] ka_cnt_q;
   logic rx_framed_q, rx_half_q;
   logic [3:0] rx_lo_q;
   logic chr_go, msg_start, release_slot, ka_fire;
   logic [7:0] chr_data;
   logic [7:0] tx_rd_data;
   logic ser_ready;

   // Power-down pin synchroniser
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pd_meta_q <= 1'b0;
         pd_q <= 1'b0;
      end else begin
         pd_meta_q <= POWER_DOWN_I;
         pd_q <= pd_meta_q;
      end
   end

   // Held configuration; power-down restores defaults
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cfg_q <= CFG_RESET;
      end else if (pd_q) begin
         cfg_q <= CFG_RESET; // see (R01)
      end else if (CFG_WE_I) begin
         cfg_q <= CFG_I; // see (R26)
      end
   end

   // Slot selector arithmetic and fill state
   wire [1:0] load_next = load_slot_selector_q + 2'h1;
   wire buf_empty = (load_slot_selector_q == send_slot_q); // see (R22)
   wire buf_full = (load_next == send_slot_q); // see (R22)
   wire clr_all = pd_q || CLEAR_OUTGOING_STORE_CMD_I; // see (R01) (R15)
   wire adv_ok = ADVANCE_LOAD_SLOT_CMD_I && !buf_full && !clr_all;
   wire adv_bad = ADVANCE_LOAD_SLOT_CMD_I && buf_full;

   // Selectors and overflow flag; clear beats everything
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         load_slot_selector_q <= SLOT_RESET;
         send_slot_q <= SLOT_RESET;
         overflow_q <= 1'b0;
      end else if (clr_all) begin
         load_slot_selector_q <= SLOT_RESET; // see (R15)
         send_slot_q <= SLOT_RESET;
         overflow_q <= 1'b0;
      end else begin
         if (adv_ok) begin
            load_slot_selector_q <= load_next; // see (R21)
         end
         if (release_slot) begin
            send_slot_q <= send_slot_q + 2'h1; // see (R23)
         end
         if (adv_bad) begin
            overflow_q <= 1'b1; // see (R22)
         end
      end
   end

   // Host writes go to the load slot; length is clamped on the way in
   wire wr_ok = WR_EN_I && WR_POS_I <= 3'h6 && !pd_q;
   wire [7:0] len_cap = cfg_q.long_msg ? LEN_CAP_LONG : LEN_CAP_SHORT;
   wire [7:0] wr_val = (WR_POS_I == 3'h0 && WR_DATA_I > len_cap) ?
                       len_cap : WR_DATA_I; // see (R16) (R06) (R14)

   // Transmit read position: length while idle or from data index 6 on, else next data byte
   wire [2:0] tx_pos = (state_q == S_IDLE || idx_q >= DATA_LAST_POS) ?
                       3'h0 : 3'(idx_q + 8'h01); // see (R14)
   wire fresh = (seen_q == {send_slot_q, tx_pos});

   utxq_slot_mem u_mem (
      .clk_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .clear_all_i(clr_all),
      .restore_i(release_slot),
      .restore_slot_i(send_slot_q),
      .wr_en_i(wr_ok),
      .wr_slot_i(load_slot_selector_q),
      .wr_pos_i(WR_POS_I),
      .wr_data_i(wr_val),
      .a_slot_i(load_slot_selector_q),
      .a_pos_i(RD_POS_I),
      .a_data_o(RD_DATA_O),
      .b_slot_i(send_slot_q),
      .b_pos_i(tx_pos),
      .b_data_o(tx_rd_data)
   ); // see (R13) (R19) (R23)

   // Character boundary, pause gate and message content selection
   wire go_ok = ser_ready && !cfg_q.pause && !pd_q; // see (R07) (R25)
   wire [7:0] fill_byte = idx_q[0] ? FILL_SECOND : FILL_FIRST; // see (R18)
   wire [7:0] data_byte = (idx_q < DATA_LAST_POS) ? tx_rd_data : fill_byte;
   wire [7:0] enc_char = m_raw_q ? data_byte :
      man_encode(half_q ? data_byte[7:4] : data_byte[3:0]); // see (R11)
   wire room_ok = cfg_q.long_msg || RX_SPACE_I >= tx_rd_data; // see (R06)
   wire start_ok = cfg_q.queue_en && !buf_empty && fresh && room_ok;

   // Keep-alive gap from the 4-bit code; zero code disables
   wire [3:0] ka_code_c = (cfg_q.ka_code > KA_TOP_CODE) ?
                          KA_TOP_CODE : cfg_q.ka_code;
   wire [KW-1:0] ka_gap = (cfg_q.ka_code == KA_ZERO_GAP) ? '0 :
      KW'(KA_MAX_CYC >> (KA_TOP_CODE - ka_code_c)); // see (R03)
   wire ka_due = cfg_q.ka_code != KA_OFF && ka_cnt_q >= ka_gap;

   // Arbiter: pause, then preambles, then queue, then keep-alive
   always_comb begin
      state_d = state_q;
      idx_d = idx_q;
      half_d = half_q;
      len_d = len_q;
      chr_go = 1'b0;
      chr_data = SOF_CHAR; // see (R24)
      msg_start = 1'b0;
      release_slot = 1'b0;
      ka_fire = 1'b0;
      case (state_q)
         S_IDLE: begin
            if (go_ok && cfg_q.preamble) begin
               chr_go = 1'b1; // see (R02)
            end else if (go_ok && start_ok) begin
               msg_start = 1'b1; // see (R05)
               len_d = tx_rd_data;
               idx_d = 8'h00;
               half_d = 1'b0;
               state_d = cfg_q.no_pre ? S_BYTE : S_SOF; // see (R10)
            end else if (go_ok && ka_due) begin
               chr_go = 1'b1; // see (R04)
               chr_data = EOF_CHAR;
               ka_fire = 1'b1;
            end
         end
         S_SOF: begin
            if (go_ok) begin
               chr_go = 1'b1;
               if (!cfg_q.preamble) begin
                  state_d = S_BYTE;
               end
            end
         end
         S_BYTE: begin
            if (idx_q == len_q) begin
               state_d = m_no_stop_q ? S_DONE : S_EOF; // see (R09)
            end else if (go_ok && cfg_q.preamble) begin
               chr_go = 1'b1; // see (R02)
            end else if (go_ok && (fresh || idx_q >= DATA_LAST_POS)) begin
               chr_go = 1'b1;
               chr_data = enc_char;
               if (m_raw_q || half_q) begin
                  idx_d = idx_q + 8'h01; // see (R18)
                  half_d = 1'b0;
               end else begin
                  half_d = 1'b1;
               end
            end
         end
         S_EOF: begin
            if (go_ok) begin
               chr_go = 1'b1;
               if (!cfg_q.preamble) begin
                  chr_data = EOF_CHAR; // see (R24)
                  state_d = S_DONE;
               end
            end
         end
         S_DONE: begin
            if (ser_ready) begin
               release_slot = 1'b1; // see (R23)
               state_d = S_IDLE;
            end
         end
         default: state_d = S_IDLE;
      endcase
   end

   // Arbiter state; clear or power-down drops any message
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_q <= S_IDLE;
         idx_q <= 8'h00;
         len_q <= LEN_RESET;
         half_q <= 1'b0;
      end else if (clr_all) begin
         state_q <= S_IDLE;
         idx_q <= 8'h00;
         len_q <= LEN_RESET;
         half_q <= 1'b0;
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
         len_q <= len_d;
         half_q <= half_d;
      end
   end

   // Per-message mode snapshot, read freshness and idle gap counter
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         m_no_stop_q <= 1'b0;
         m_raw_q <= 1'b0;
         seen_q <= 5'h1f;
         ka_cnt_q <= '0;
      end else begin
         if (msg_start) begin
            m_no_stop_q <= cfg_q.no_stop; // see (R26)
            m_raw_q <= cfg_q.tx_raw;
         end
         seen_q <= {send_slot_q, tx_pos};
         if (chr_go || state_q != S_IDLE || !ser_ready || pd_q) begin
            ka_cnt_q <= '0;
         end else if (ka_cnt_q != KW'(KA_MAX_CYC)) begin
            ka_cnt_q <= ka_cnt_q + KW'(1);
         end
      end
   end

   utxq_char_ser #(.BAUD_DIV(BAUD_DIV)) u_ser (
      .clk_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .halt_i(pd_q),
      .chr_valid_i(chr_go),
      .chr_data_i(chr_data),
      .odd_par_i(cfg_q.odd_par),
      .chr_ready_o(ser_ready),
      .line_o(TX_LINE_O)
   ); // see (R08) (R01)

   // Status; busy and idle freeze while paused
   wire busy_now = (state_q != S_IDLE) || !ser_ready;
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         STATUS_O <= STAT_RESET;
      end else begin
         STATUS_O.empty <= buf_empty;
         STATUS_O.full <= buf_full;
         STATUS_O.overflow <= overflow_q;
         STATUS_O.load_slot <= load_slot_selector_q;
         STATUS_O.send_slot <= send_slot_q;
         if (!cfg_q.pause || pd_q) begin
            STATUS_O.busy <= busy_now && !pd_q; // see (R07)
            STATUS_O.idle <= !busy_now || pd_q;
         end
      end
   end

   // Receive byte assembly: framed data only, raw or Manchester pairs
   wire rx_sof = RX_CHAR_I == SOF_CHAR;
   wire rx_eof = RX_CHAR_I == EOF_CHAR;
   wire rx_data = RX_CHAR_VALID_I && !rx_sof && !rx_eof && rx_framed_q;
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rx_framed_q <= 1'b0;
         rx_half_q <= 1'b0;
         rx_lo_q <= 4'h0;
         RX_BYTE_VALID_O <= 1'b0;
         RX_BYTE_O <= 8'h00;
      end else if (pd_q) begin
         rx_framed_q <= 1'b0; // see (R01)
         rx_half_q <= 1'b0;
         rx_lo_q <= 4'h0;
         RX_BYTE_VALID_O <= 1'b0;
         RX_BYTE_O <= 8'h00;
      end else begin
         RX_BYTE_VALID_O <= rx_data && (cfg_q.rx_raw || rx_half_q);
         if (RX_CHAR_VALID_I && (rx_sof || rx_eof)) begin
            rx_framed_q <= rx_sof; // see (R10)
            rx_half_q <= 1'b0;
         end else if (rx_data && cfg_q.rx_raw) begin
            RX_BYTE_O <= RX_CHAR_I; // see (R12)
         end else if (rx_data && rx_half_q) begin
            RX_BYTE_O <= {man_decode(RX_CHAR_I), rx_lo_q};
            rx_half_q <= 1'b0;
         end else if (rx_data) begin
            rx_lo_q <= man_decode(RX_CHAR_I);
            rx_half_q <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);

   property p_pause;
      cfg_q.pause |-> !chr_go;
   endproperty
   a_pause: assert property (p_pause) // see (R07)
      else $error("character started while paused");

   property p_preamble;
      (chr_go && cfg_q.preamble) |-> chr_data == 8'h15;
   endproperty
   a_preamble: assert property (p_preamble) // see (R02)
      else $error("non-preamble character in preamble mode");

   property p_ka_low;
      ka_fire |-> state_q == S_IDLE && !cfg_q.preamble && !start_ok;
   endproperty
   a_ka_low: assert property (p_ka_low) // see (R04)
      else $error("keep-alive beat a higher mode");

   property p_start;
      msg_start |-> cfg_q.queue_en && !buf_empty &&
         (cfg_q.long_msg || RX_SPACE_I >= tx_rd_data);
   endproperty
   a_start: assert property (p_start) // see (R05)
      else $error("message started without room");

   property p_refuse;
      (ADVANCE_LOAD_SLOT_CMD_I && buf_full && !clr_all) |=>
         load_slot_selector_q == $past(load_slot_selector_q) && overflow_q;
   endproperty
   a_refuse: assert property (p_refuse) // see (R22)
      else $error("advance while full not refused");

   property p_advance;
      adv_ok |=> load_slot_selector_q == 2'($past(load_slot_selector_q) + 1);
   endproperty
   a_advance: assert property (p_advance) // see (R21)
      else $error("load selector did not advance");

   property p_clear;
      CLEAR_OUTGOING_STORE_CMD_I |=> load_slot_selector_q == 2'h0 &&
         send_slot_q == 2'h0 && state_q == S_IDLE;
   endproperty
   a_clear: assert property (p_clear) // see (R15)
      else $error("clear did not reset selectors");

   property p_release;
      (release_slot && !clr_all) |=>
         send_slot_q == 2'($past(send_slot_q) + 1) ##1
         state_q == S_IDLE || clr_all;
   endproperty
   a_release: assert property (p_release) // see (R23)
      else $error("sent slot not released");

   property p_fill;
      (chr_go && state_q == S_BYTE && m_raw_q && idx_q >= 8'h06 &&
       !cfg_q.preamble) |-> chr_data == (idx_q[0] ? 8'hc2 : 8'hd3);
   endproperty
   a_fill: assert property (p_fill) // see (R18)
      else $error("wrong fill byte");

   property p_shutdown;
      pd_q |=> state_q == S_IDLE && load_slot_selector_q == 2'h0 &&
         cfg_q == CFG_RESET ##1 TX_LINE_O;
   endproperty
   a_shutdown: assert property (p_shutdown) // see (R01)
      else $error("power-down did not reset the block");
endmodule
`default_nettype wire

//--- utxq_chain_model.sv
// Far-side chain model: decodes line characters, echoes them back
`timescale 1ns/100ps
`default_nettype none
module utxq_chain_model #(
   parameter int DIV = 4
)(
   // Clock and line
   input wire logic clk_i,
   input wire logic line_i,
   // Echoed character and its parity bit
   output logic v_o,
   output logic [7:0] c_o,
   output logic p_o
);
   logic [8:0] sh;
   // Sample mid-cell, pulse, then scramble the held data
   initial begin
      {v_o, c_o, p_o} = 10'h000;
      forever begin
         @(negedge line_i);
         repeat (DIV + DIV / 2) @(posedge clk_i);
         for (int i = 0; i < 9; i++) begin
            sh[i] = line_i;
            repeat (DIV) @(posedge clk_i);
         end
         {v_o, p_o, c_o} <= {1'b1, sh};
         @(posedge clk_i);
         v_o <= 1'b0;
         c_o <= ~sh[7:0];
      end
   end
endmodule
`default_nettype wire

//--- utxq_top_bench.sv
// Self-checking bench for the transmit mode and slot block
`timescale 1ns/100ps
`default_nettype none
module utxq_top_bench
   import utxq_pkg::*;
;
   logic clk, rst_n, pd, cwe, clr, adv, we, rv, bv, line, par, odd;
   logic [2:0] wp, rp;
   logic [7:0] wd, rd, sp, rc, rb;
   utxq_cfg_s cfg, nc;
   utxq_stat_s st;
   int bad_count = 0;
   int check_count = 0;
   logic [7:0] chq[$], rxq[$];
   utxq_top #(.BAUD_DIV(4), .KA_MAX_CYC(2048)) dut_u (
      .CLOCK_I(clk), .RST_N_I(rst_n), .POWER_DOWN_I(pd),
      .CFG_WE_I(cwe), .CFG_I(cfg), .CLEAR_OUTGOING_STORE_CMD_I(clr),
      .ADVANCE_LOAD_SLOT_CMD_I(adv), .WR_EN_I(we), .WR_POS_I(wp),
      .WR_DATA_I(wd), .RD_POS_I(rp), .RD_DATA_O(rd), .STATUS_O(st),
      .RX_SPACE_I(sp), .RX_CHAR_VALID_I(rv), .RX_CHAR_I(rc),
      .RX_BYTE_VALID_O(bv), .RX_BYTE_O(rb), .TX_LINE_O(line));
   utxq_chain_model #(.DIV(4)) chain_u (
      .clk_i(clk), .line_i(line), .v_o(rv), .c_o(rc), .p_o(par));
   // Clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Collect line characters and bytes, judge parity
   always @(posedge clk) begin
      if (rv === 1'b1) begin
         chq.push_back(rc);
         chk("parity", ^{par, rc}, odd);
      end
      if (bv === 1'b1) rxq.push_back(rb);
   end
   // Compare and count
   task automatic chk(input string n, input logic [8:0] g, e);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Host operation: 0 write, 1 advance, 2 clear, 3 config, 4 read
   task automatic op(input int k, input logic [2:0] p, input logic [7:0] d);
      @(posedge clk);
      {we, adv, clr, cwe} <= {k == 0, k == 1, k == 2, k == 3};
      {wp, rp, wd, cfg} <= {p, p, d, nc};
      @(posedge clk);
      {we, adv, clr, cwe} <= 4'h0;
      repeat (3) @(posedge clk);
   endtask
   // Bounded wait for n characters, then compare them
   task automatic wt(input int n, input logic [7:0] e[$]);
      for (int i = 0; i < 3000 && chq.size() < n; i++) @(posedge clk);
      repeat (100) @(posedge clk);
      foreach (e[i]) chk("char", chq[i], e[i]);
      chk("count", chq.size(), n);
      chq = {};
   endtask
   // Slot defaults and length clamp
   task automatic t_store();
      op(2, 3'h0, 8'h00);
      chk("status", st, STAT_RESET);
      op(4, 3'h1, 8'h00);
      chk("pos1", rd, FILL_FIRST);
      op(4, 3'h4, 8'h00);
      chk("pos4", rd, FILL_SECOND);
      op(0, 3'h0, 8'h50);
      chk("len", rd, LEN_CAP_SHORT);
      nc.long_msg = 1'b1;
      op(3, 3'h0, 8'h00);
      op(0, 3'h0, 8'hff);
      chk("len", rd, 8'hff);
      nc = CFG_RESET;
      op(3, 3'h0, 8'h00);
   endtask
   // Framed encoded message held until the receive side has room
   task automatic t_msg();
      sp <= 8'h02;
      op(0, 3'h0, 8'h03);
      op(0, 3'h1, 8'h57);
      op(0, 3'h2, 8'h00);
      op(0, 3'h3, 8'h00);
      op(1, 3'h0, 8'h00);
      repeat (200) @(posedge clk);
      chk("held", chq.size(), 0);
      sp <= 8'h3e;
      wt(8, {8'h15, 8'h95, 8'h99, 8'haa, 8'haa, 8'haa, 8'haa,
         8'h54});
      chk("rx", rxq[0], 8'h57);
      chk("rxn", rxq.size(), 3);
      chk("empty", st.empty, 1'b1);
      chk("send", st.send_slot, 2'h1);
   endtask
   // Raw, odd parity, no end character, fill bytes
   task automatic t_raw();
      {nc.tx_raw, nc.odd_par, nc.no_stop} = 3'h7;
      op(3, 3'h0, 8'h00);
      odd = 1'b1;
      op(0, 3'h0, 8'h08);
      op(0, 3'h1, 8'ha5);
      op(1, 3'h0, 8'h00);
      wt(9, {8'h15, 8'ha5, 8'hc2, 8'hd3, 8'hc2, 8'hd3, 8'hc2,
         8'hd3, 8'hc2});
   endtask
   // Fill to full, refused advance, then power-down
   task automatic t_full();
      nc = CFG_RESET;
      nc.queue_en = 1'b0;
      op(3, 3'h0, 8'h00);
      odd = 1'b0;
      repeat (3) op(1, 3'h0, 8'h00);
      chk("full", st.full, 1'b1);
      chk("load", st.load_slot, 2'h1);
      op(1, 3'h0, 8'h00);
      chk("ovf", st.overflow, 1'b1);
      chk("load", st.load_slot, 2'h1);
      pd <= 1'b1;
      repeat (8) @(posedge clk);
      chk("pd", st, STAT_RESET);
      pd <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   // Preambles beat keep-alive, then a lone keep-alive end character
   task automatic t_modes();
      nc.preamble = 1'b1;
      nc.ka_code = KA_TOP_CODE;
      op(3, 3'h0, 8'h00);
      repeat (300) @(posedge clk);
      nc.preamble = 1'b0;
      op(3, 3'h0, 8'h00);
      repeat (100) @(posedge clk);
      chk("pre", chq[0], SOF_CHAR);
      chk("prelast", chq[$], SOF_CHAR);
      chq = {};
      wt(1, {EOF_CHAR});
      nc.ka_code = KA_OFF;
      op(3, 3'h0, 8'h00);
   endtask
   // Report and stop
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      {rst_n, pd, cwe, clr, adv, we, odd} = 7'h00;
      {wp, rp, wd, sp} = 22'h00003e;
      cfg = CFG_RESET;
      nc = CFG_RESET;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_store();
      t_msg();
      t_raw();
      t_full();
      t_modes();
      end_sim();
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      end_sim();
   end
endmodule
`default_nettype wire
